// >>> msq_pkg.sv
// package of constants and types for the motor start sequencer
package msq_pkg;

   // register offsets on the plain register port
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PERIOD = 8'h08;

   // config register field positions
   localparam int SDE_BIT = 0;
   localparam int RDE_BIT = 1;
   localparam int STO_LSB = 2;
   localparam int RSL_LSB = 4;
   localparam int BRK_LSB = 6;
   localparam int PDC_LSB = 9;
   localparam int AC1_LSB = 13;
   localparam int AC2_LSB = 16;
   localparam int HOV_LSB = 19;
   localparam logic [31:0] CFG_MASK = 32'h00FF_FFFF;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // status register field positions
   localparam int ST_LSB = 0;
   localparam int FWD_BIT = 4;
   localparam int DIR_BIT = 5;
   localparam int SEC_LSB = 6;

   // drive patterns: align drives phase two high and phase three low
   localparam logic [2:0] ALIGN_HIGH = 3'b010;
   localparam logic [2:0] ALIGN_LOW = 3'b100;
   localparam logic [2:0] ALL_ON = 3'b111;

   // times and derived cycle counts
   localparam int CLK_HZ = 50_000_000;
   localparam int STILL_BASE_US = 100_000;
   localparam int BRAKE_BASE_US = 50_000;
   localparam int ALIGN_US = 40_000;
   localparam int REV_BASE_US = 10_000;
   localparam int ACCEL_STEP_US = 1_000;
   localparam int STILL_CYC = (CLK_HZ / 1_000_000) * STILL_BASE_US;
   localparam int BRAKE_CYC = (CLK_HZ / 1_000_000) * BRAKE_BASE_US;
   localparam int ALIGN_CYC = (CLK_HZ / 1_000_000) * ALIGN_US;
   localparam int REV_CYC = (CLK_HZ / 1_000_000) * REV_BASE_US;
   localparam int ACCEL_CYC = (CLK_HZ / 1_000_000) * ACCEL_STEP_US;

   typedef enum logic [3:0] {
      S_POWER_ON, S_SPEED_DETECT, S_BRAKE, S_POS_DETECT, S_ALIGN,
      S_ACCEL, S_REVERSE_DRIVE, S_CLOSED_LOOP
   } msq_state_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } msq_bus_type;

   typedef struct packed {
      logic [2:0] high_on;
      logic [2:0] low_on;
      logic open_loop;
      logic closed_loop;
      logic pos_detect_run;
      logic [15:0] rate;
      logic [2:0] sector;
   } msq_drive_type;
endpackage : msq_pkg

// >>> msq_motor_start_sequencer.sv
// motor start sequencer: power-on to closed-loop commutation
// Behaviour
// - start at power-on after reset or standby exit
// - speed detect if enabled, else brake check
// - phases high-impedance during speed detection
// - forward if lag sixty degrees, reverse if lead
// - speed from interval between comparator rising edges
// - no toggle within selected timeout means stationary
// - slow goes brake check, fast goes direction check
// - forward to closed loop, reverse to limit check
// - resync loads captured speed and position
// - too fast reverse returns to speed detection
// - reverse drive if enabled, else brake check
// - reverse drive decelerates, zero speed then accelerate
// - brake enabled when duration field nonzero
// - hold brake for duration, then position check
// - position detect if current nonzero, else align
// - position detect done leads to accelerate
// - align done leads to accelerate
// - ramp rate by first and second coefficients
// - exceed handover threshold enters closed loop
// - closed loop uses commutation feedback
// - direction pin change stops drive, restarts sequence
// - brake disabled starts as stationary rotor
// - brake turns on all three low sides
// - brake ends after current low for duration
// - align drives phase two in, phase three out
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module msq_motor_start_sequencer #(
   parameter int STILL_TICKS = msq_pkg::STILL_CYC,
   parameter int BRAKE_TICKS = msq_pkg::BRAKE_CYC,
   parameter int ALIGN_TICKS = msq_pkg::ALIGN_CYC,
   parameter int REV_TICKS = msq_pkg::REV_CYC,
   parameter int ACCEL_TICKS = msq_pkg::ACCEL_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire msq_pkg::msq_bus_type bus_req,
   output logic [31:0] reg_rdata,
   input wire logic standby,
   input wire logic dir_pin,
   input wire logic comparator_phase_one_two,
   input wire logic comparator_phase_one_three,
   input wire logic brake_current_low,
   input wire logic pos_detect_done,
   output msq_pkg::msq_drive_type drive
);

   typedef struct packed {
      msq_pkg::msq_state_type st;
      logic [31:0] cfg;
      logic [31:0] rdata;
      logic stby_s1;
      logic stby_s2;
      logic dir_s1;
      logic dir_s2;
      logic dir_q;
      logic c12_s1;
      logic c12_s2;
      logic c12_q;
      logic c13_s1;
      logic c13_s2;
      logic c13_q;
      logic low_s1;
      logic low_s2;
      logic [31:0] timer;
      logic [31:0] period;
      logic [1:0] edges;
      logic dir_ok;
      logic fwd;
      logic [15:0] slope;
      msq_pkg::msq_drive_type drv;
   } msq_reg_type;

   msq_reg_type r;
   msq_reg_type n;

   // config fields
   logic sde;
   logic rde;
   logic [1:0] sto;
   logic [1:0] rsl;
   logic [2:0] brk;
   logic [3:0] pdc;
   logic [2:0] ac1;
   logic [2:0] ac2;
   logic [4:0] hov;
   logic abort;
   logic rise_c12;
   logic rise_c13;
   logic [15:0] hov_rate;
   logic [15:0] step;

   assign sde = r.cfg[msq_pkg::SDE_BIT];
   assign rde = r.cfg[msq_pkg::RDE_BIT];
   assign sto = r.cfg[msq_pkg::STO_LSB +: 2];
   assign rsl = r.cfg[msq_pkg::RSL_LSB +: 2];
   assign brk = r.cfg[msq_pkg::BRK_LSB +: 3];
   assign pdc = r.cfg[msq_pkg::PDC_LSB +: 4];
   assign ac1 = r.cfg[msq_pkg::AC1_LSB +: 3];
   assign ac2 = r.cfg[msq_pkg::AC2_LSB +: 3];
   assign hov = r.cfg[msq_pkg::HOV_LSB +: 5];

   // standby or a direction pin edge aborts any state
   assign abort = r.stby_s2 | (r.dir_s2 != r.dir_q);
   assign rise_c12 = r.c12_s2 & ~r.c12_q;
   assign rise_c13 = r.c13_s2 & ~r.c13_q;
   assign hov_rate = {5'h00, hov, 6'h00};
   assign step = {13'h0000, ac1} + 16'h0001;

   // brake check, then position-detect check
   function automatic msq_pkg::msq_state_type after_brake_check(
      input logic [2:0] b,
      input logic [3:0] p
   );
      if (b != 3'h0) begin
         return msq_pkg::S_BRAKE;
      end else if (p != 4'h0) begin
         return msq_pkg::S_POS_DETECT;
      end else begin
         return msq_pkg::S_ALIGN;
      end
   endfunction : after_brake_check

   // next-state logic for the whole block
   always_comb begin
      n = r;
      n.stby_s1 = standby;
      n.stby_s2 = r.stby_s1;
      n.dir_s1 = dir_pin;
      n.dir_s2 = r.dir_s1;
      n.dir_q = r.dir_s2;
      n.c12_s1 = comparator_phase_one_two;
      n.c12_s2 = r.c12_s1;
      n.c12_q = r.c12_s2;
      n.c13_s1 = comparator_phase_one_three;
      n.c13_s2 = r.c13_s1;
      n.c13_q = r.c13_s2;
      n.low_s1 = brake_current_low;
      n.low_s2 = r.low_s1;
      n.timer = r.timer + 32'h0000_0001;

      // register port: write config, read one cycle later
      n.rdata = 32'h0000_0000;
      if (bus_req.wr && bus_req.addr == msq_pkg::ADDR_CONFIG) begin
         n.cfg = bus_req.wdata & msq_pkg::CFG_MASK;
      end
      if (bus_req.rd) begin
         if (bus_req.addr == msq_pkg::ADDR_CONFIG) begin
            n.rdata = r.cfg;
         end else if (bus_req.addr == msq_pkg::ADDR_STATUS) begin
            n.rdata[msq_pkg::ST_LSB +: 4] = r.st;
            n.rdata[msq_pkg::FWD_BIT] = r.fwd;
            n.rdata[msq_pkg::DIR_BIT] = r.dir_s2;
            n.rdata[msq_pkg::SEC_LSB +: 3] = r.drv.sector;
         end else if (bus_req.addr == msq_pkg::ADDR_PERIOD) begin
            n.rdata = r.period;
         end else begin
            n.rdata = 32'h0000_0000;
         end
      end

      // sequencer
      if (abort) begin
         n.st = msq_pkg::S_POWER_ON;
      end else begin
         case (r.st)
            msq_pkg::S_POWER_ON: begin
               if (sde) begin
                  n.st = msq_pkg::S_SPEED_DETECT;
                  n.edges = 2'd0;
                  n.dir_ok = 1'b0;
               end else begin
                  n.st = after_brake_check(brk, pdc);
               end
            end
            msq_pkg::S_SPEED_DETECT: begin
               if (rise_c12 || rise_c13) begin
                  n.timer = 32'h0000_0000;
                  if (r.edges != 2'd0) begin
                     n.period = r.timer;
                  end
                  if (r.edges != 2'd2) begin
                     n.edges = r.edges + 2'd1;
                  end
               end
               if (rise_c12) begin
                  n.fwd = ~r.c13_s2;
                  n.dir_ok = 1'b1;
               end
               if (r.timer >= (32'(STILL_TICKS) << sto)) begin
                  n.st = after_brake_check(brk, pdc);
               end else if (r.edges == 2'd2 && r.dir_ok) begin
                  if (r.fwd) begin
                     n.st = msq_pkg::S_CLOSED_LOOP;
                     n.drv.rate = ~r.period[23:8];
                     n.drv.sector = {1'b0, r.c13_s2, r.c12_s2};
                  end else if (r.period < (32'(REV_TICKS) << rsl)) begin
                     n.edges = 2'd0;
                     n.dir_ok = 1'b0;
                     n.timer = 32'h0000_0000;
                  end else if (rde) begin
                     n.st = msq_pkg::S_REVERSE_DRIVE;
                     n.drv.rate = ~r.period[23:8];
                  end else begin
                     n.st = after_brake_check(brk, pdc);
                  end
               end
            end
            msq_pkg::S_BRAKE: begin
               if (!r.low_s2) begin
                  n.timer = 32'h0000_0000;
               end else if (r.timer >= (32'(BRAKE_TICKS) << brk)) begin
                  n.st = (pdc != 4'h0) ? msq_pkg::S_POS_DETECT
                                       : msq_pkg::S_ALIGN;
               end
            end
            msq_pkg::S_POS_DETECT: begin
               if (pos_detect_done) begin
                  n.st = msq_pkg::S_ACCEL;
                  n.drv.rate = 16'h0000;
                  n.slope = 16'h0000;
               end
            end
            msq_pkg::S_ALIGN: begin
               if (r.timer >= 32'(ALIGN_TICKS)) begin
                  n.st = msq_pkg::S_ACCEL;
                  n.drv.rate = 16'h0000;
                  n.slope = 16'h0000;
               end
            end
            msq_pkg::S_REVERSE_DRIVE: begin
               if (r.timer >= 32'(ACCEL_TICKS)) begin
                  n.timer = 32'h0000_0000;
                  if (r.drv.rate <= step) begin
                     n.drv.rate = 16'h0000;
                     n.slope = 16'h0000;
                     n.st = msq_pkg::S_ACCEL;
                  end else begin
                     n.drv.rate = r.drv.rate - step;
                  end
               end
            end
            msq_pkg::S_ACCEL: begin
               if (r.drv.rate > hov_rate) begin
                  n.st = msq_pkg::S_CLOSED_LOOP;
               end else if (r.timer >= 32'(ACCEL_TICKS)) begin
                  n.timer = 32'h0000_0000;
                  n.slope = r.slope + {13'h0000, ac2};
                  n.drv.rate = r.drv.rate + {13'h0000, ac1} + r.slope;
               end
            end
            msq_pkg::S_CLOSED_LOOP: begin
               n.st = msq_pkg::S_CLOSED_LOOP;
            end
            default: begin
               n.st = msq_pkg::S_POWER_ON;
            end
         endcase
      end
      if (n.st != r.st) begin
         n.timer = 32'h0000_0000;
      end

      // phase drive follows the next state
      n.drv.high_on = 3'b000;
      n.drv.low_on = 3'b000;
      n.drv.open_loop = 1'b0;
      n.drv.closed_loop = 1'b0;
      n.drv.pos_detect_run = 1'b0;
      case (n.st)
         msq_pkg::S_BRAKE: begin
            n.drv.low_on = msq_pkg::ALL_ON;
         end
         msq_pkg::S_ALIGN: begin
            n.drv.high_on = msq_pkg::ALIGN_HIGH;
            n.drv.low_on = msq_pkg::ALIGN_LOW;
         end
         msq_pkg::S_POS_DETECT: begin
            n.drv.pos_detect_run = 1'b1;
         end
         msq_pkg::S_ACCEL, msq_pkg::S_REVERSE_DRIVE: begin
            n.drv.open_loop = 1'b1;
         end
         msq_pkg::S_CLOSED_LOOP: begin
            n.drv.closed_loop = 1'b1;
         end
         default: begin
            n.drv.high_on = 3'b000;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.st <= msq_pkg::S_POWER_ON;
         r.cfg <= msq_pkg::CFG_RESET;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata = r.rdata;
   assign drive = r.drv;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_abort;
      r.stby_s2 || (r.dir_s2 != r.dir_q);
   endsequence

   sequence s_dir_edge;
      r.dir_s2 != r.dir_q;
   endsequence

   property p_standby_hold;
      r.stby_s2 |=> r.st == msq_pkg::S_POWER_ON;
   endproperty
   a_standby_hold: assert property (p_standby_hold)
      else $error("standby did not hold power-on");

   property p_power_on_route;
      r.st == msq_pkg::S_POWER_ON && !abort && sde
         |=> r.st == msq_pkg::S_SPEED_DETECT;
   endproperty
   a_power_on_route: assert property (p_power_on_route)
      else $error("power-on did not enter speed detect");

   property p_detect_hiz;
      r.st == msq_pkg::S_SPEED_DETECT |-> r.drv.high_on == 3'b000 && r.drv.low_on == 3'b000;
   endproperty
   a_detect_hiz: assert property (p_detect_hiz)
      else $error("phases driven during speed detect");

   property p_dir_restart;
      s_dir_edge |=> r.st == msq_pkg::S_POWER_ON ##1 r.drv.open_loop == 1'b0;
   endproperty
   a_dir_restart: assert property (p_dir_restart)
      else $error("direction change did not restart");

   property p_skip_brake;
      r.st == msq_pkg::S_POWER_ON && !abort && !sde && brk == 3'h0 && pdc == 4'h0
         |=> r.st == msq_pkg::S_ALIGN;
   endproperty
   a_skip_brake: assert property (p_skip_brake)
      else $error("disabled brake not skipped");

   property p_brake_low;
      r.st == msq_pkg::S_BRAKE |-> r.drv.low_on == 3'b111 && r.drv.high_on == 3'b000;
   endproperty
   a_brake_low: assert property (p_brake_low)
      else $error("brake pattern wrong");

   property p_brake_wait;
      r.st == msq_pkg::S_BRAKE && !r.low_s2 && !abort |=> r.st == msq_pkg::S_BRAKE;
   endproperty
   a_brake_wait: assert property (p_brake_wait)
      else $error("brake left with current high");

   property p_align_pattern;
      r.st == msq_pkg::S_ALIGN |-> r.drv.high_on == 3'b010 && r.drv.low_on == 3'b100;
   endproperty
   a_align_pattern: assert property (p_align_pattern)
      else $error("align pattern wrong");

   property p_pos_detect_done;
      r.st == msq_pkg::S_POS_DETECT && pos_detect_done && !abort
         |=> r.st == msq_pkg::S_ACCEL && r.drv.rate == 16'h0000;
   endproperty
   a_pos_detect_done: assert property (p_pos_detect_done)
      else $error("position detect done not followed");

   property p_handover;
      r.st == msq_pkg::S_ACCEL && r.drv.rate > hov_rate && !abort
         |=> r.st == msq_pkg::S_CLOSED_LOOP ##0 r.drv.closed_loop;
   endproperty
   a_handover: assert property (p_handover)
      else $error("handover to closed loop missed");

   property p_abort_any;
      s_abort |=> r.drv.high_on == 3'b000 && r.drv.low_on == 3'b000;
   endproperty
   a_abort_any: assert property (p_abort_any)
      else $error("drive not stopped on abort");
endmodule : msq_motor_start_sequencer

// >>> msq_motor_model.sv
// behavioural motor seen through the two back-emf comparators
`timescale 1ns/1ps
module msq_motor_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic spin,
   input wire logic forward,
   input wire logic [15:0] half_period,
   output logic comparator_phase_one_two,
   output logic comparator_phase_one_three
);
   int cnt;
   int per;
   int sixth;
   int shifted;

   // phase counter; a still rotor leaves both comparators where they stood
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         comparator_phase_one_two <= 1'b0;
         comparator_phase_one_three <= 1'b0;
      end else if (spin) begin
         per = 2 * int'(half_period);
         sixth = per / 6;
         cnt <= (cnt + 1) % per;
         // one-three lags by sixty degrees forward, leads in reverse
         shifted = forward ? (cnt + per - sixth) % per : (cnt + sixth) % per;
         comparator_phase_one_two <= (cnt < int'(half_period));
         comparator_phase_one_three <= (shifted < int'(half_period));
      end
   end
endmodule : msq_motor_model

// >>> msq_motor_start_sequencer_bench.sv
// self-checking bench for the motor start sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module msq_motor_start_sequencer_bench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   msq_pkg::msq_bus_type bus_req = '0;
   logic [31:0] reg_rdata;
   logic standby = 1'b0;
   logic dir_pin = 1'b0;
   logic brake_current_low = 1'b0;
   logic pos_detect_done = 1'b0;
   logic cmp12;
   logic cmp13;
   logic spin = 1'b0;
   logic fwd = 1'b1;
   logic [15:0] half = 16'h0018;
   logic [31:0] rv;
   msq_pkg::msq_drive_type drive;
   msq_pkg::msq_drive_type drive_now;
   int n_fail = 0;
   int checks = 0;

   // 50 MHz clock
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   // drive outputs copied mid-cycle, where they have settled
   always @(negedge clk_sys) begin
      drive <= drive_now;
   end

   msq_motor_start_sequencer #(.STILL_TICKS(50), .BRAKE_TICKS(20), .ALIGN_TICKS(30),
      .REV_TICKS(10), .ACCEL_TICKS(4)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
      .standby(standby), .dir_pin(dir_pin), .comparator_phase_one_two(cmp12),
      .comparator_phase_one_three(cmp13), .brake_current_low(brake_current_low),
      .pos_detect_done(pos_detect_done), .drive(drive_now));

   msq_motor_model i_motor (
      .clk_sys(clk_sys), .rst(rst), .spin(spin), .forward(fwd), .half_period(half),
      .comparator_phase_one_two(cmp12), .comparator_phase_one_three(cmp13));

   // config word from its fields
   function automatic logic [31:0] cfg(input int sde, input int rde, input int sto,
      input int rsl, input int brk, input int pdc, input int c1, input int hov);
      cfg = (32'(sde) << msq_pkg::SDE_BIT) | (32'(rde) << msq_pkg::RDE_BIT) |
         (32'(sto) << msq_pkg::STO_LSB) | (32'(rsl) << msq_pkg::RSL_LSB) |
         (32'(brk) << msq_pkg::BRK_LSB) | (32'(pdc) << msq_pkg::PDC_LSB) |
         (32'(c1) << msq_pkg::AC1_LSB) | (32'(hov) << msq_pkg::HOV_LSB);
   endfunction : cfg

   task automatic tally_and_finish();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask : wr_reg

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk_sys);
   endtask : rd_reg

   // poll the status state field under a bound
   task automatic wait_state(input msq_pkg::msq_state_type s, input int bound);
      logic [31:0] d;
      int i;
      for (i = 0; i < bound; i++) begin
         rd_reg(msq_pkg::ADDR_STATUS, d);
         if (d[3:0] === 4'(s)) break;
      end
      if (i == bound) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, d[3:0], 4'(s));
         tally_and_finish();
      end
   endtask : wait_state

   // standby pulse restarts the sequencer from power-on
   task automatic restart(input logic [31:0] c);
      logic [31:0] d;
      wr_reg(msq_pkg::ADDR_CONFIG, c);
      standby <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rd_reg(msq_pkg::ADDR_STATUS, d);
      `CHK(d[3:0], 4'(msq_pkg::S_POWER_ON))
      `CHK({drive.high_on, drive.low_on}, 6'h00)
      standby <= 1'b0;
   endtask : restart

   // main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd_reg(msq_pkg::ADDR_CONFIG, rv);
      `CHK(rv, msq_pkg::CFG_RESET)
      rd_reg(8'h0C, rv);
      `CHK(rv, 32'h0000_0000)
      // all options off: straight to align
      wait_state(msq_pkg::S_ALIGN, 20);
      `CHK(drive.high_on, msq_pkg::ALIGN_HIGH)
      `CHK(drive.low_on, msq_pkg::ALIGN_LOW)
      wr_reg(msq_pkg::ADDR_CONFIG, 32'hFFFF_FFFF);
      rd_reg(msq_pkg::ADDR_CONFIG, rv);
      `CHK(rv, msq_pkg::CFG_MASK)
      // second-order coefficient of one: handover after eleven steps
      rv = cfg(0, 0, 0, 0, 0, 0, 1, 1) | (32'h0000_0001 << msq_pkg::AC2_LSB);
      wr_reg(msq_pkg::ADDR_CONFIG, rv);
      wait_state(msq_pkg::S_ACCEL, 40);
      `CHK(drive.open_loop, 1'b1)
      wait_state(msq_pkg::S_CLOSED_LOOP, 40);
      `CHK(drive.closed_loop, 1'b1)
      // direction change in closed loop restarts the sequence
      dir_pin <= ~dir_pin;
      wait_state(msq_pkg::S_ALIGN, 20);
      `CHK(drive.closed_loop, 1'b0)
      rd_reg(msq_pkg::ADDR_STATUS, rv);
      `CHK(rv[msq_pkg::DIR_BIT], 1'b1)
      // brake, held while current stays high, then position detect
      restart(cfg(0, 0, 0, 0, 1, 1, 7, 0));
      wait_state(msq_pkg::S_BRAKE, 20);
      `CHK(drive.low_on, msq_pkg::ALL_ON)
      repeat (100) @(posedge clk_sys);
      rd_reg(msq_pkg::ADDR_STATUS, rv);
      `CHK(rv[3:0], 4'(msq_pkg::S_BRAKE))
      brake_current_low <= 1'b1;
      repeat (30) @(posedge clk_sys);
      rd_reg(msq_pkg::ADDR_STATUS, rv);
      `CHK(rv[3:0], 4'(msq_pkg::S_BRAKE))
      wait_state(msq_pkg::S_POS_DETECT, 30);
      `CHK(drive.pos_detect_run, 1'b1)
      pos_detect_done <= 1'b1;
      @(posedge clk_sys);
      pos_detect_done <= 1'b0;
      wait_state(msq_pkg::S_ACCEL, 10);
      // speed detect with a still rotor times out
      brake_current_low <= 1'b0;
      restart(cfg(1, 0, 0, 0, 0, 0, 1, 1));
      wait_state(msq_pkg::S_SPEED_DETECT, 10);
      `CHK({drive.high_on, drive.low_on}, 6'h00)
      wait_state(msq_pkg::S_ALIGN, 100);
      // forward spin resynchronises into closed loop
      spin <= 1'b1;
      restart(cfg(1, 0, 3, 0, 0, 0, 1, 1));
      wait_state(msq_pkg::S_CLOSED_LOOP, 300);
      rd_reg(msq_pkg::ADDR_STATUS, rv);
      `CHK(rv[msq_pkg::FWD_BIT], 1'b1)
      `CHK(drive.rate, 16'hFFFF)
      // fast reverse spin keeps the sequencer in speed detect
      fwd <= 1'b0;
      half <= 16'h000C;
      restart(cfg(1, 1, 3, 3, 0, 0, 7, 1));
      repeat (300) @(posedge clk_sys);
      rd_reg(msq_pkg::ADDR_STATUS, rv);
      `CHK(rv[3:0], 4'(msq_pkg::S_SPEED_DETECT))
      // slow reverse spin goes to reverse drive, then to accelerate
      half <= 16'h003C;
      restart(cfg(1, 1, 3, 0, 0, 0, 7, 1));
      wait_state(msq_pkg::S_REVERSE_DRIVE, 300);
      `CHK(drive.open_loop, 1'b1)
      spin <= 1'b0;
      wait_state(msq_pkg::S_ACCEL, 22000);
      tally_and_finish();
   end
endmodule : msq_motor_start_sequencer_bench
